// ==== design/ppc_pkg.sv ====
// Package for the PCI port control and status register bank.
// Assumes one bridge clock; register offsets are byte offsets in the page.
package ppc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] CMD_OFS    = 12'h810;
  localparam logic [11:0] STS_OFS    = 12'h814;
  localparam logic [11:0] MLT_OFS    = 12'h81c;
  localparam logic [11:0] TLT_OFS    = 12'h830;

  // ==========================================================================
  // Command register fields (bit 0 is the least significant)
  localparam int CMD_SEC_RST  = 6;
  localparam int CMD_FBB_GEN  = 5;
  localparam int CMD_MWI      = 4;
  localparam int CMD_SYSTEM_ERROR_DRIVE_ENABLE  = 3;
  localparam int CMD_PAR_CHK  = 2;
  localparam int CMD_LOW_RANGE_UPSTREAM_ENABLE  = 1;
  localparam int CMD_NEGATIVE_DECODE_ENABLE  = 0;
  localparam logic [6:0] CMD_RESET = 7'h00;

  // ==========================================================================
  // Status register fields
  localparam int STS_FBB_CAP  = 8;
  localparam int STS_DPD      = 7;
  localparam int STS_DEVSEL   = 5;
  localparam int STS_STA      = 4;
  localparam int STS_RTA      = 3;
  localparam int STS_RMA      = 2;
  localparam int STS_SSE      = 1;
  localparam int STS_DPE      = 0;
  localparam logic [1:0] DEVSEL_TIMING = 2'h1;
  localparam logic [5:0] STS_RESET     = 6'h00;

  // ==========================================================================
  // Latency timers
  localparam int MLT_WIDTH      = 8;
  localparam int MLT_ZERO_BITS  = 3;
  localparam int TLT_WIDTH      = 7;
  localparam int TLT_ZERO_BITS  = 2;
  localparam int TLT_EN_BIT     = 7;
  localparam logic [7:0] MLT_RESET   = 8'h00;
  localparam logic [6:0] TLT_RESET   = 7'h00;
  localparam logic [6:0] TLT_DEFAULT = 7'h08;

  // ==========================================================================
  // Upstream decode windows
  localparam logic [31:0] LOW_TOP  = 32'hefff_ffff;
  localparam logic [31:0] NEG_BASE = 32'hf000_0000;

endpackage

// ==== design/ppc_lat_timer.sv ====
// Down-counting latency timer with a one-cycle expiry pulse.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ppc_lat_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] load_val,
  output logic              running,
  output logic              expired
);

  // ==========================================================================
  // Elaboration check
  if (W < 2) begin : g_chk
    $error("ppc_lat_timer: W must be at least 2");
  end

  logic [W-1:0] cnt_q;

  // Count state; a zero load expires at once rather than hanging
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      running <= 1'b0;
    end else if (stop) begin
      running <= 1'b0;
    end else if (start) begin
      cnt_q   <= load_val;
      running <= (load_val != '0);
    end else if (running) begin
      cnt_q   <= cnt_q - 1'b1;
      running <= (cnt_q != {{(W-1){1'b0}}, 1'b1});
    end
  end

  // Expiry pulse on the last count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      expired <= 1'b0;
    end else begin
      expired <= !stop && ((start && load_val == '0) ||
                 (!start && running && cnt_q == {{(W-1){1'b0}}, 1'b1}));
    end
  end

endmodule
`default_nettype wire

// ==== design/ppc_regs.sv ====
// Control and status register bank of the downstream PCI port.
// Assumes register accesses and PCI event strobes share clk.
`timescale 1ns/1ps
`default_nettype none
module ppc_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic        bus_id_load,
  input  wire logic        cmd_reset,
  input  wire logic        cmd_clear,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  // PCI side events
  input  wire logic        is_master,
  input  wire logic        perr_seen,
  input  wire logic        parity_mismatch,
  input  wire logic        data_sink,
  input  wire logic        tgt_abort_sent,
  input  wire logic        tgt_abort_rcvd,
  input  wire logic        mst_abort,
  input  wire logic        mst_abort_cfg,
  input  wire logic        serr_req,
  input  wire logic        mst_start,
  input  wire logic        mst_stop,
  input  wire logic        tgt_start,
  input  wire logic        tgt_stop,
  input  wire logic        up_valid,
  input  wire logic        up_is_mem,
  input  wire logic [31:0] up_addr,
  // PCI side controls
  output logic             pci_rst_n,
  output logic             fast_b2b_gen_enable,
  output logic             parity_err_report,
  output logic             serr_out,
  output logic             serr_oe_n,
  output logic             mst_lat_expired,
  output logic             tgt_lat_expired,
  output logic             up_fwd_low,
  output logic             up_neg_claim
);

  // ==========================================================================
  // Helpers
  function automatic logic sticky(input logic set, input logic old, input logic clr);
    sticky = set | (old & ~clr);
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================================
  // State
  logic        bus_id_valid_q;
  logic [6:0]  cmd_q;
  logic [7:0]  mlt_q;
  logic        tlt_en_q;
  logic [6:0]  tlt_q;
  logic        dpd_q, sta_q, rta_q, rma_q, sse_q, dpe_q;
  logic        acc_wr, acc_rd, sts_clr;
  logic        system_error_drive_enable, par_chk;
  logic [6:0]  tgt_cnt;
  logic        mst_lat_run, tgt_lat_run, mst_exp, tgt_exp;

  // Accesses are dropped until the bus id has been loaded
  assign acc_wr  = reg_wr && bus_id_valid_q;
  assign acc_rd  = reg_rd && bus_id_valid_q;
  assign sts_clr = cmd_clear || (acc_wr && hit(reg_addr, ppc_pkg::STS_OFS));
  assign system_error_drive_enable = cmd_q[ppc_pkg::CMD_SYSTEM_ERROR_DRIVE_ENABLE];
  assign par_chk = cmd_q[ppc_pkg::CMD_PAR_CHK];

  // Bus id gate; a command reset does not forget the id
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_id_valid_q <= 1'b0;
    end else if (bus_id_load) begin
      bus_id_valid_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Command register
  always_ff @(posedge clk) begin
    if (!rst_n || cmd_reset) begin
      cmd_q <= ppc_pkg::CMD_RESET;
    end else if (acc_wr && hit(reg_addr, ppc_pkg::CMD_OFS)) begin
      cmd_q <= reg_wdata[6:0];
      cmd_q[ppc_pkg::CMD_MWI] <= 1'b0;
    end
  end

  // Timer registers; hardwired low bits never store
  always_ff @(posedge clk) begin
    if (!rst_n || cmd_reset) begin
      mlt_q    <= ppc_pkg::MLT_RESET;
      tlt_en_q <= 1'b0;
      tlt_q    <= ppc_pkg::TLT_RESET;
    end else if (acc_wr) begin
      if (hit(reg_addr, ppc_pkg::MLT_OFS)) begin
        mlt_q <= {reg_wdata[7:ppc_pkg::MLT_ZERO_BITS], 3'h0};
      end
      if (hit(reg_addr, ppc_pkg::TLT_OFS)) begin
        tlt_en_q <= reg_wdata[ppc_pkg::TLT_EN_BIT];
        tlt_q    <= {reg_wdata[6:ppc_pkg::TLT_ZERO_BITS], 2'h0};
      end
    end
  end

  // ==========================================================================
  // Sticky status flags; a same-cycle event beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n || cmd_reset) begin
      {dpd_q, sta_q, rta_q, rma_q, sse_q, dpe_q} <= ppc_pkg::STS_RESET;
    end else begin
      dpd_q <= sticky(is_master && perr_seen && par_chk, dpd_q, sts_clr);
      sta_q <= sticky(tgt_abort_sent, sta_q, sts_clr);
      rta_q <= sticky(tgt_abort_rcvd, rta_q, sts_clr);
      rma_q <= sticky(mst_abort && !mst_abort_cfg, rma_q, sts_clr);
      sse_q <= sticky(!serr_oe_n, sse_q, sts_clr);
      dpe_q <= sticky(data_sink && parity_mismatch, dpe_q, sts_clr);
    end
  end

  // ==========================================================================
  // Read data; unmapped offsets answer zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= acc_rd;
      if (acc_rd) begin
        reg_rdata <= 32'h0000_0000;
        case (reg_addr)
          ppc_pkg::CMD_OFS: begin
            reg_rdata[6:0] <= cmd_q;
            reg_rdata[ppc_pkg::CMD_MWI] <= 1'b0;
          end
          ppc_pkg::STS_OFS: begin
            reg_rdata[ppc_pkg::STS_FBB_CAP] <= 1'b1;
            reg_rdata[ppc_pkg::STS_DPD]     <= dpd_q;
            reg_rdata[6:5] <= ppc_pkg::DEVSEL_TIMING;
            reg_rdata[4:0] <= {sta_q, rta_q, rma_q, sse_q, dpe_q};
          end
          ppc_pkg::MLT_OFS: begin
            reg_rdata[7:0] <= mlt_q;
          end
          ppc_pkg::TLT_OFS: begin
            reg_rdata[7:0] <= {tlt_en_q, tlt_q};
          end
          default: begin
            reg_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // PCI side controls; reset stays asserted until software releases it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pci_rst_n           <= 1'b0;
      fast_b2b_gen_enable <= 1'b0;
      parity_err_report   <= 1'b0;
    end else begin
      pci_rst_n           <= cmd_q[ppc_pkg::CMD_SEC_RST];
      fast_b2b_gen_enable <= cmd_q[ppc_pkg::CMD_FBB_GEN];
      // The master parity flag dpd_q is also gated by this bit; dpe_q is not
      parity_err_report   <= par_chk && parity_mismatch;
    end
  end

  // SERR is open drain: driven low only while enabled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serr_out  <= 1'b1;
      serr_oe_n <= 1'b1;
    end else begin
      serr_out  <= 1'b0;
      serr_oe_n <= !(serr_req && system_error_drive_enable);
    end
  end

  // Upstream decode, one cycle after the address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_fwd_low   <= 1'b0;
      up_neg_claim <= 1'b0;
    end else begin
      up_fwd_low   <= up_valid && up_addr <= ppc_pkg::LOW_TOP &&
                      cmd_q[ppc_pkg::CMD_LOW_RANGE_UPSTREAM_ENABLE];
      up_neg_claim <= up_valid && up_is_mem && up_addr >= ppc_pkg::NEG_BASE &&
                      cmd_q[ppc_pkg::CMD_NEGATIVE_DECODE_ENABLE];
    end
  end

  // ==========================================================================
  // Latency timers
  assign tgt_cnt = tlt_en_q ? tlt_q : ppc_pkg::TLT_DEFAULT;

  ppc_lat_timer #(.W(ppc_pkg::MLT_WIDTH)) u_mst_lat (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (mst_start && is_master),
    .stop     (mst_stop),
    .load_val (mlt_q),
    .running  (mst_lat_run),
    .expired  (mst_exp)
  );

  ppc_lat_timer #(.W(ppc_pkg::TLT_WIDTH)) u_tgt_lat (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (tgt_start),
    .stop     (tgt_stop),
    .load_val (tgt_cnt),
    .running  (tgt_lat_run),
    .expired  (tgt_exp)
  );

  // Expiry pulses retimed so outputs come from flops here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mst_lat_expired <= 1'b0;
      tgt_lat_expired <= 1'b0;
    end else begin
      mst_lat_expired <= mst_exp;
      tgt_lat_expired <= tgt_exp;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_release_write;
    acc_wr && hit(reg_addr, ppc_pkg::CMD_OFS) && reg_wdata[ppc_pkg::CMD_SEC_RST]
      && !cmd_reset;
  endsequence

  sequence s_read_of(logic [11:0] ofs);
    acc_rd && reg_addr == ofs ##1 reg_rvalid;
  endsequence

  rst_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_release_write |=> ##1 pci_rst_n)
    else $error("reset not released after write");

  rst_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_reset |=> ##1 !pci_rst_n)
    else $error("reset not asserted after command reset");

  mwi_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_of(ppc_pkg::CMD_OFS) |-> reg_rdata[31:7] == '0 && !reg_rdata[4])
    else $error("command read shows fixed-zero bits set");

  serr_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !serr_oe_n |-> $past(system_error_drive_enable) && $past(serr_req))
    else $error("SERR driven while disabled");

  fixed_sts_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_of(ppc_pkg::STS_OFS) |-> reg_rdata[ppc_pkg::STS_FBB_CAP] &&
      reg_rdata[6:5] == ppc_pkg::DEVSEL_TIMING && reg_rdata[31:9] == '0)
    else $error("status fixed bits wrong");

  dpd_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dpd_q) |-> $past(is_master && perr_seen && par_chk))
    else $error("master parity flag set without cause");

  low_range_upstream_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    up_valid && up_addr <= ppc_pkg::LOW_TOP |=> up_fwd_low == $past(cmd_q[ppc_pkg::CMD_LOW_RANGE_UPSTREAM_ENABLE]))
    else $error("low range forward mismatch");

  negative_decode_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    up_neg_claim |-> $past(cmd_q[ppc_pkg::CMD_NEGATIVE_DECODE_ENABLE]) && $past(up_addr) >= ppc_pkg::NEG_BASE)
    else $error("negative decode without enable");

  sse_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    !serr_oe_n && !cmd_reset |=> sse_q)
    else $error("SERR drive did not set flag");

  sts_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    sts_clr && !(is_master && perr_seen) && !tgt_abort_sent && !tgt_abort_rcvd &&
    !mst_abort && serr_oe_n && !parity_mismatch |=> {dpd_q, sta_q, rta_q, rma_q, dpe_q} == '0)
    else $error("status not cleared");

  mlt_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_of(ppc_pkg::MLT_OFS) |-> reg_rdata[2:0] == 3'h0 && reg_rdata[31:8] == '0)
    else $error("master timer low bits not zero");

  tlt_def_a: assert property (@(posedge clk) disable iff (!rst_n)
    tgt_start && !tgt_stop && !tlt_en_q && !tgt_lat_run |=> tgt_lat_run [*8] ##1 !tgt_lat_run)
    else $error("default target count is not eight");

  busid_a: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_id_valid_q |=> !reg_rvalid)
    else $error("answer before bus id loaded");

  // A start while another agent masters must not arm the timer
  mst_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    mst_start && !is_master && !mst_stop && !mst_lat_run |=> !mst_lat_run)
    else $error("master timer started while not master");

  fbb_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> fast_b2b_gen_enable == $past(cmd_q[ppc_pkg::CMD_FBB_GEN]))
    else $error("fast back-to-back enable does not follow command");

  par_report_a: assert property (@(posedge clk) disable iff (!rst_n)
    !par_chk |=> !parity_err_report)
    else $error("parity reported while checking disabled");

  dpe_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    data_sink && parity_mismatch && !cmd_reset |=> dpe_q)
    else $error("sink parity error did not set flag");

  sta_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    tgt_abort_sent && !cmd_reset |=> sta_q)
    else $error("signalled target abort did not set flag");

endmodule
`default_nettype wire

// ==== sim/ppc_pci_agent.sv ====
// PCI agent model: turns a numbered event request into the PCI-side pulses.
// Assumes requests arrive on the bench clock, one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module ppc_pci_agent (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [2:0] kind,
  input  wire logic       master_hold,
  output logic            is_master,
  output logic            perr_seen,
  output logic            parity_mismatch,
  output logic            data_sink,
  output logic            tgt_abort_sent,
  output logic            tgt_abort_rcvd,
  output logic            mst_abort,
  output logic            mst_abort_cfg,
  output logic            serr_req
);
  logic mst_q;
  // ==========================================================================
  // Event pulses, one cycle after the request; levels ride with them
  always_ff @(posedge clk) begin
    tgt_abort_sent  <= go && kind == 3'h0;
    tgt_abort_rcvd  <= go && kind == 3'h1;
    mst_abort       <= go && (kind == 3'h2 || kind == 3'h3);
    mst_abort_cfg   <= go && kind == 3'h3;
    parity_mismatch <= go && kind == 3'h4;
    data_sink       <= go && kind == 3'h4;
    perr_seen       <= go && kind == 3'h5;
    mst_q           <= go && kind == 3'h5;
    serr_req        <= go && kind == 3'h6;
  end
  // Master level also held for timer runs
  assign is_master = master_hold | mst_q;
endmodule
`default_nettype wire

// ==== sim/pci_port_control_status_tb.sv ====
// Self-checking bench for the PCI port control and status registers.
// Assumes ppc_regs and the PCI agent model run on one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pci_port_control_status_tb;
  logic clk = 0, rst_n = 0, bus_id_load = 0, cmd_reset = 0, cmd_clear = 0;
  logic reg_wr = 0, reg_rd = 0, go = 0, master_hold = 0, up_valid = 0, up_is_mem = 0;
  logic mst_start = 0, tgt_start = 0, saw_drive = 0, saw_per = 0;
  logic [2:0] kind = 3'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, up_addr = 32'h0, reg_rdata, lfsr = 32'h1;
  logic reg_rvalid, is_master, perr_seen, parity_mismatch, data_sink, tgt_abort_sent;
  logic tgt_abort_rcvd, mst_abort, mst_abort_cfg, serr_req, pci_rst_n, fast_b2b_gen_enable;
  logic parity_err_report, serr_out, serr_oe_n, mst_lat_expired, tgt_lat_expired;
  logic up_fwd_low, up_neg_claim;
  logic [31:0] exp_q[$];
  int miscompares = 0, cmp_count = 0, cycles = 0;
  localparam logic [31:0] ST0 = 32'h0000_0120;
  logic [31:0] on_mask [7] = '{32'h10, 32'h08, 32'h04, 32'h00, 32'h01, 32'h80, 32'h02};

  ppc_pci_agent agent_u (.clk(clk), .go(go), .kind(kind), .master_hold(master_hold),
    .is_master(is_master), .perr_seen(perr_seen), .parity_mismatch(parity_mismatch),
    .data_sink(data_sink), .tgt_abort_sent(tgt_abort_sent), .tgt_abort_rcvd(tgt_abort_rcvd),
    .mst_abort(mst_abort), .mst_abort_cfg(mst_abort_cfg), .serr_req(serr_req));
  ppc_regs dut_u (.clk(clk), .rst_n(rst_n), .bus_id_load(bus_id_load), .cmd_reset(cmd_reset),
    .cmd_clear(cmd_clear), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .is_master(is_master), .perr_seen(perr_seen), .parity_mismatch(parity_mismatch),
    .data_sink(data_sink), .tgt_abort_sent(tgt_abort_sent), .tgt_abort_rcvd(tgt_abort_rcvd),
    .mst_abort(mst_abort), .mst_abort_cfg(mst_abort_cfg), .serr_req(serr_req),
    .mst_start(mst_start), .mst_stop(1'b0), .tgt_start(tgt_start), .tgt_stop(1'b0),
    .up_valid(up_valid), .up_is_mem(up_is_mem), .up_addr(up_addr), .pci_rst_n(pci_rst_n),
    .fast_b2b_gen_enable(fast_b2b_gen_enable), .parity_err_report(parity_err_report),
    .serr_out(serr_out), .serr_oe_n(serr_oe_n), .mst_lat_expired(mst_lat_expired),
    .tgt_lat_expired(tgt_lat_expired), .up_fwd_low(up_fwd_low), .up_neg_claim(up_neg_claim));

  // ==========================================================================
  // Clock, cycle ceiling and SERR drive watcher
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (serr_oe_n === 1'b0) saw_drive = 1'b1;
    if (parity_err_report === 1'b1) saw_per = 1'b1;
    if (cycles > 20000) begin
      miscompares++;
      test_done();
    end
  end

  // ==========================================================================
  // Read answers taken off the queue as they appear
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected rvalid", 32'h0, 32'h1);
      else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Two edges per access keeps the strobe from being assigned twice at once
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input bit noted);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    if (noted) exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // One-cycle strobe: 0 bus id, 1 clear, 2 command reset, 3 master start, else target start
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: bus_id_load <= 1'b1;
      1: cmd_clear <= 1'b1;
      2: cmd_reset <= 1'b1;
      3: mst_start <= 1'b1;
      default: tgt_start <= 1'b1;
    endcase
    @(posedge clk);
    {bus_id_load, cmd_clear, cmd_reset, mst_start, tgt_start} <= 5'h00;
  endtask
  task automatic ev(input logic [2:0] k);
    @(posedge clk);
    go <= 1'b1; kind <= k;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Cycles after the start edge until the retimed pulse stands; looked at mid-cycle
  task automatic tmr(input bit m, input int exp_n);
    int n;
    n = 0;
    pulse(m ? 3 : 4);
    while (n < 400) begin
      @(negedge clk);
      n++;
      if ((m ? mst_lat_expired : tgt_lat_expired) === 1'b1) break;
    end
    chk("latency cycles", exp_n, n);
  endtask
  task automatic dec(input logic [31:0] a, input logic mem, input logic [31:0] cmd);
    @(posedge clk);
    up_valid <= 1'b1; up_addr <= a; up_is_mem <= mem;
    @(posedge clk);
    up_valid <= 1'b0;
    @(posedge clk);
    chk("up_fwd_low", {31'h0, cmd[1] && a <= 32'hefff_ffff}, {31'h0, up_fwd_low});
    chk("up_neg_claim", {31'h0, cmd[0] && mem && a >= 32'hf000_0000},
        {31'h0, up_neg_claim});
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // Accesses before the bus id are dropped
    wr(ppc_pkg::CMD_OFS, 32'h40);
    rd(ppc_pkg::STS_OFS, 32'h0, 0);
    repeat (3) @(posedge clk);
    chk("pci_rst_n", 32'h0, {31'h0, pci_rst_n});
    chk("serr_oe_n", 32'h1, {31'h0, serr_oe_n});
    chk("serr_out", 32'h0, {31'h0, serr_out});
    pulse(0);
    rd(ppc_pkg::CMD_OFS, 32'h0, 1);
    rd(ppc_pkg::STS_OFS, ST0, 1);
    rd(12'h818, 32'h0, 1);
    wr(ppc_pkg::STS_OFS, 32'hffff_ffff);
    rd(ppc_pkg::STS_OFS, ST0, 1);
    $display("Reset and access gating done");
    // Command and timer fields, all ones written
    wr(ppc_pkg::CMD_OFS, 32'hffff_ffff);
    wr(ppc_pkg::MLT_OFS, 32'hffff_ffff);
    wr(ppc_pkg::TLT_OFS, 32'hffff_ffff);
    rd(ppc_pkg::CMD_OFS, 32'h6f, 1);
    rd(ppc_pkg::MLT_OFS, 32'hf8, 1);
    rd(ppc_pkg::TLT_OFS, 32'hfc, 1);
    chk("pci_rst_n", 32'h1, {31'h0, pci_rst_n});
    chk("fast_b2b_gen_enable", 32'h1, {31'h0, fast_b2b_gen_enable});
    $display("Field access done");
    // Every event kind with parity check and SERR drive enabled
    for (int k = 0; k < 7; k++) begin
      ev(k[2:0]);
      rd(ppc_pkg::STS_OFS, ST0 | on_mask[k], 1);
      wr(ppc_pkg::STS_OFS, 32'h0);
    end
    chk("serr driven", 32'h1, {31'h0, saw_drive});
    chk("parity_err_report", 32'h1, {31'h0, saw_per});
    // Parity check and SERR drive off
    wr(ppc_pkg::CMD_OFS, 32'h40);
    saw_drive = 1'b0;
    saw_per = 1'b0;
    for (int k = 4; k < 7; k++) begin
      ev(k[2:0]);
      rd(ppc_pkg::STS_OFS, ST0 | (k == 4 ? 32'h1 : 32'h0), 1);
      wr(ppc_pkg::STS_OFS, 32'h0);
    end
    chk("serr driven", 32'h0, {31'h0, saw_drive});
    chk("parity_err_report", 32'h0, {31'h0, saw_per});
    ev(3'h0);
    ev(3'h1);
    pulse(1);
    rd(ppc_pkg::STS_OFS, ST0, 1);
    $display("Status events done");
    // Decode windows: boundaries then random addresses, both enable settings
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      if (i == 12) wr(ppc_pkg::CMD_OFS, 32'h43);
      dec(i % 12 == 0 ? 32'hefff_ffff : i % 12 == 1 ? 32'hf000_0000 : lfsr, lfsr[3],
          i < 12 ? 32'h40 : 32'h43);
    end
    $display("Decode windows done");
    // Latency timers: fixed eight, programmed count, master count
    // Expected: count plus one internal stage and one retiming stage
    wr(ppc_pkg::TLT_OFS, 32'h7f);
    tmr(0, 10);
    wr(ppc_pkg::TLT_OFS, 32'h8c);
    tmr(0, 14);
    // Not master: the start is ignored and no expiry ever comes
    tmr(1, 400);
    master_hold <= 1'b1;
    wr(ppc_pkg::MLT_OFS, 32'h17);
    tmr(1, 18);
    master_hold <= 1'b0;
    $display("Latency timers done");
    // Command reset puts the PCI bus back in reset
    ev(3'h0);
    pulse(2);
    rd(ppc_pkg::CMD_OFS, 32'h0, 1);
    rd(ppc_pkg::STS_OFS, ST0, 1);
    rd(ppc_pkg::MLT_OFS, 32'h0, 1);
    repeat (3) @(posedge clk);
    chk("pci_rst_n", 32'h0, {31'h0, pci_rst_n});
    $display("Command reset done");
    test_done();
  end
endmodule
`default_nettype wire
